// *** stve_exc_model.sv ***
// Stand-in for the exception logic that collects faults from the unit
`timescale 1ns/100ps
module stve_exc_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Completion from the unit
  input wire logic done,
  input wire logic fault,
  input wire logic [7:0] fault_vector,
  // Faults taken so far
  output logic [7:0] taken_q,
  output logic [7:0] last_vec_q
);
  // Faults are only valid with done, so count only when done and fault are both high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      taken_q <= 8'h00;
      last_vec_q <= 8'h00;
    end else if (done && fault) begin
      taken_q <= taken_q + 8'h01;
      last_vec_q <= fault_vector;
    end
  end
endmodule

// *** stve_exec_unit.sv ***
// Execution unit for subtract, logical compare, reserved opcode and segment verify
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module stve_exec_unit (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Issue from decode and operand fetch
  input wire logic issue_valid,
  input wire logic op_ext,
  input wire logic [7:0] op_byte,
  input wire logic [2:0] modrm_reg,
  input wire logic [1:0] op_size,
  input wire logic [31:0] dst_value,
  input wire logic [31:0] src_value,
  input wire logic [31:0] imm_value,
  // Memory operand description
  input wire logic mem_operand,
  input wire logic [31:0] mem_ea,
  input wire logic [31:0] seg_limit,
  input wire logic seg_is_stack,
  input wire logic seg_is_data_reg,
  input wire logic seg_null,
  input wire logic seg_writable,
  input wire logic page_fail,
  input wire logic [31:0] page_fault_code,
  // Descriptor looked up for verification
  input wire logic desc_in_table,
  input wire logic desc_code_data,
  input wire logic [3:0] desc_type,
  input wire logic [1:0] desc_priv,
  // Results
  output logic done,
  output logic [2:0] done_class,
  output logic result_we,
  output logic result_to_mem,
  output logic [31:0] result,
  output logic [5:0] flags_mask,
  output logic [5:0] flags,
  output logic fault,
  output logic [7:0] fault_vector,
  output logic [31:0] fault_code,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [31:0] ctrl_q;
  logic [31:0] count_q;
  logic [1:0] mode;
  logic [1:0] cur_priv;
  logic align_en;
  logic fire;
  stve_pkg::stve_cls_t cls_d;
  stve_pkg::stve_cls_t cls_q;
  logic uses_imm;
  logic byte_op;
  logic rm_dst;
  logic [4:0] msb_idx;
  logic [1:0] size;
  logic [31:0] mask;
  logic [31:0] a_op;
  logic [31:0] b_op;
  logic [31:0] sub_res;
  logic [31:0] and_res;
  logic a_msb;
  logic b_msb;
  logic r_msb;
  logic t_msb;
  logic [5:0] sub_flags;
  logic [5:0] test_flags;
  logic [32:0] mem_end;
  logic unaligned;
  logic [15:0] sel;
  logic verify_ok;
  logic fault_d;
  logic [7:0] vec_d;
  logic [31:0] code_d;

  assign mode = ctrl_q[stve_pkg::CTRL_MODE_LSB +: 2];
  assign align_en = ctrl_q[stve_pkg::CTRL_ALIGN_BIT];
  assign cur_priv = ctrl_q[stve_pkg::CTRL_PRIV_LSB +: 2];
  assign fire = issue_valid && ce;
  // Register-destination subtract forms only read the memory operand
  assign rm_dst = !(op_byte == stve_pkg::OPC_SUB_R8_RM8 || op_byte == stve_pkg::OPC_SUB_R_RM ||
                    op_byte == stve_pkg::OPC_SUB_AL_IMM || op_byte == stve_pkg::OPC_SUB_ACC_IMM);

  // Decode
  always_comb begin
    cls_d = stve_pkg::CLS_NONE;
    uses_imm = 1'b0;
    byte_op = 1'b0;
    if (op_ext) begin
      if (op_byte == stve_pkg::OPC_EXT_UNDEF) begin
        cls_d = stve_pkg::CLS_UNDEF;
      end else if (op_byte == stve_pkg::OPC_EXT_GRP6 && modrm_reg == stve_pkg::EXT_VERIFY_RD) begin
        cls_d = stve_pkg::CLS_VRD;
      end else if (op_byte == stve_pkg::OPC_EXT_GRP6 && modrm_reg == stve_pkg::EXT_VERIFY_WR) begin
        cls_d = stve_pkg::CLS_VWR;
      end
    end else begin
      case (op_byte)
        stve_pkg::OPC_SUB_RM8_R8, stve_pkg::OPC_SUB_R8_RM8: begin
          cls_d = stve_pkg::CLS_SUB;
          byte_op = 1'b1;
        end
        stve_pkg::OPC_SUB_RM_R, stve_pkg::OPC_SUB_R_RM: begin
          cls_d = stve_pkg::CLS_SUB;
        end
        stve_pkg::OPC_SUB_AL_IMM: begin
          cls_d = stve_pkg::CLS_SUB;
          uses_imm = 1'b1;
          byte_op = 1'b1;
        end
        stve_pkg::OPC_SUB_ACC_IMM: begin
          cls_d = stve_pkg::CLS_SUB;
          uses_imm = 1'b1;
        end
        stve_pkg::OPC_GRP1_RM8_IMM, stve_pkg::OPC_GRP1_RM_IMM, stve_pkg::OPC_GRP1_RM_IMM8: begin
          if (modrm_reg == stve_pkg::EXT_SUB) begin
            cls_d = stve_pkg::CLS_SUB;
          end
          uses_imm = 1'b1;
          byte_op = (op_byte == stve_pkg::OPC_GRP1_RM8_IMM);
        end
        stve_pkg::OPC_TEST_RM8_R8: begin
          cls_d = stve_pkg::CLS_TEST;
          byte_op = 1'b1;
        end
        stve_pkg::OPC_TEST_RM_R: begin
          cls_d = stve_pkg::CLS_TEST;
        end
        stve_pkg::OPC_TEST_AL_IMM, stve_pkg::OPC_GRP3_RM8: begin
          if (op_byte == stve_pkg::OPC_TEST_AL_IMM || modrm_reg == stve_pkg::EXT_TEST) begin
            cls_d = stve_pkg::CLS_TEST;
          end
          uses_imm = 1'b1;
          byte_op = 1'b1;
        end
        stve_pkg::OPC_TEST_ACC_IMM, stve_pkg::OPC_GRP3_RM: begin
          if (op_byte == stve_pkg::OPC_TEST_ACC_IMM || modrm_reg == stve_pkg::EXT_TEST) begin
            cls_d = stve_pkg::CLS_TEST;
          end
          uses_imm = 1'b1;
        end
        default: begin
          cls_d = stve_pkg::CLS_NONE;
        end
      endcase
    end
  end

  // Verify always works on a 16-bit selector whatever the operand size
  assign size = byte_op ? stve_pkg::SIZE_BYTE :
                (cls_d == stve_pkg::CLS_VRD || cls_d == stve_pkg::CLS_VWR) ? stve_pkg::SIZE_WORD : op_size;
  assign mask = (size == stve_pkg::SIZE_BYTE) ? 32'h0000_00FF :
                (size == stve_pkg::SIZE_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;

  // Operands; the 83 form widens its byte immediate by sign
  always_comb begin
    a_op = dst_value & mask;
    b_op = src_value & mask;
    if (uses_imm) begin
      if (!op_ext && op_byte == stve_pkg::OPC_GRP1_RM_IMM8) begin
        b_op = {{24{imm_value[7]}}, imm_value[7:0]} & mask;
      end else begin
        b_op = imm_value & mask;
      end
    end
  end

  assign sub_res = (a_op - b_op) & mask;
  assign and_res = a_op & b_op;

  // Sign position follows the operand size
  assign msb_idx = (size == stve_pkg::SIZE_BYTE) ? 5'h07 : (size == stve_pkg::SIZE_WORD) ? 5'h0F : 5'h1F;
  assign a_msb = a_op[msb_idx];
  assign b_msb = b_op[msb_idx];
  assign r_msb = sub_res[msb_idx];
  assign t_msb = and_res[msb_idx];

  always_comb begin
    sub_flags = 6'h00;
    sub_flags[stve_pkg::FLAG_CARRY] = a_op < b_op;
    sub_flags[stve_pkg::FLAG_OVER] = (a_msb ^ b_msb) & (a_msb ^ r_msb);
    sub_flags[stve_pkg::FLAG_SIGN] = r_msb;
    sub_flags[stve_pkg::FLAG_AUX] = a_op[4] ^ b_op[4] ^ sub_res[4];
    sub_flags[stve_pkg::FLAG_ZERO] = (sub_res == 32'h0000_0000);
    sub_flags[stve_pkg::FLAG_PARITY] = ~^sub_res[7:0];
    test_flags = 6'h00;
    test_flags[stve_pkg::FLAG_SIGN] = t_msb;
    test_flags[stve_pkg::FLAG_ZERO] = (and_res == 32'h0000_0000);
    test_flags[stve_pkg::FLAG_PARITY] = ~^and_res[7:0];
  end

  // Memory operand checks
  assign mem_end = {1'b0, mem_ea} + ((size == stve_pkg::SIZE_BYTE) ? 33'h0_0000_0000 :
                   (size == stve_pkg::SIZE_WORD) ? 33'h0_0000_0001 : 33'h0_0000_0003);
  assign unaligned = (size == stve_pkg::SIZE_WORD && mem_ea[0]) ||
                     (size == stve_pkg::SIZE_DWORD && mem_ea[1:0] != 2'h0);

  // Segment verification
  assign sel = src_value[15:0];
  always_comb begin
    verify_ok = (sel[15:2] != 14'h0000) && desc_in_table && desc_code_data;
    if (cls_d == stve_pkg::CLS_VWR) begin
      verify_ok = verify_ok && !desc_type[3] && desc_type[1];
    end else begin
      verify_ok = verify_ok && (!desc_type[3] || desc_type[1]);
    end
    if (!(desc_type[3] && desc_type[2])) begin
      verify_ok = verify_ok && (desc_priv >= cur_priv) && (desc_priv >= sel[1:0]);
    end
  end

  // Fault priority: opcode, then segment, limit, write, page, alignment
  always_comb begin
    fault_d = 1'b0;
    vec_d = 8'h00;
    code_d = 32'h0000_0000;
    if (cls_d == stve_pkg::CLS_UNDEF || cls_d == stve_pkg::CLS_NONE) begin
      fault_d = 1'b1;
      vec_d = stve_pkg::VEC_INVALID_OPCODE;
    end else if ((cls_d == stve_pkg::CLS_VRD || cls_d == stve_pkg::CLS_VWR) && mode != stve_pkg::MODE_PROT) begin
      fault_d = 1'b1;
      vec_d = stve_pkg::VEC_INVALID_OPCODE;
    end else if (mem_operand) begin
      if (mode == stve_pkg::MODE_PROT && seg_is_data_reg && seg_null) begin
        fault_d = 1'b1;
        vec_d = stve_pkg::VEC_GENERAL;
      end else if (mem_end > {1'b0, seg_limit}) begin
        fault_d = 1'b1;
        vec_d = seg_is_stack ? stve_pkg::VEC_STACK : stve_pkg::VEC_GENERAL;
      end else if (mode == stve_pkg::MODE_PROT && cls_d == stve_pkg::CLS_SUB && rm_dst && !seg_writable) begin
        fault_d = 1'b1;
        vec_d = stve_pkg::VEC_GENERAL;
      end else if (mode != stve_pkg::MODE_REAL && page_fail) begin
        fault_d = 1'b1;
        vec_d = stve_pkg::VEC_PAGE;
        code_d = page_fault_code;
      end else if (align_en && unaligned &&
                   (mode == stve_pkg::MODE_V86 || (mode == stve_pkg::MODE_PROT && cur_priv == stve_pkg::PRIV_USER))) begin
        fault_d = 1'b1;
        vec_d = stve_pkg::VEC_ALIGN;
      end
    end
  end

  // Result stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done <= 1'b0;
      cls_q <= stve_pkg::CLS_NONE;
      result_we <= 1'b0;
      result_to_mem <= 1'b0;
      result <= 32'h0000_0000;
      flags_mask <= 6'h00;
      flags <= 6'h00;
      fault <= 1'b0;
      fault_vector <= 8'h00;
      fault_code <= 32'h0000_0000;
    end else if (ce) begin
      done <= issue_valid;
      result_we <= 1'b0;
      if (issue_valid) begin
        cls_q <= cls_d;
        fault <= fault_d;
        fault_vector <= vec_d;
        fault_code <= code_d;
        result_to_mem <= mem_operand && rm_dst;
        result <= 32'h0000_0000;
        flags_mask <= 6'h00;
        flags <= 6'h00;
        if (!fault_d) begin
          case (cls_d)
            stve_pkg::CLS_SUB: begin
              result_we <= 1'b1;
              result <= sub_res;
              flags_mask <= stve_pkg::MASK_ALL;
              flags <= sub_flags;
            end
            stve_pkg::CLS_TEST: begin
              flags_mask <= stve_pkg::MASK_TEST;
              flags <= test_flags;
            end
            stve_pkg::CLS_VRD, stve_pkg::CLS_VWR: begin
              flags_mask <= stve_pkg::MASK_ZERO;
              flags[stve_pkg::FLAG_ZERO] <= verify_ok;
            end
            default: begin
              flags_mask <= 6'h00;
            end
          endcase
        end
      end
    end
  end
  assign done_class = cls_q;

  // Count of instructions that complete without a fault, readable by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 32'h0000_0000;
    end else if (fire && !fault_d) begin
      count_q <= count_q + 32'h0000_0001;
    end
  end

  // Register write channel; address and data are taken together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= stve_pkg::CTRL_RESET;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (ce) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (!s_axi_bvalid && !s_axi_awready && s_axi_awvalid && s_axi_wvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      // Response and write only at the handshake edge, never before it
      if (s_axi_awready && s_axi_awvalid) begin
        s_axi_bvalid <= 1'b1;
        if (s_axi_awaddr[3:2] == stve_pkg::ADDR_CTRL[3:2]) begin
          s_axi_bresp <= 2'h0;
          if (s_axi_wstrb[0]) begin
            ctrl_q[7:0] <= s_axi_wdata[7:0];
          end
        end else begin
          // Status and count are read only, so writes there are refused too
          s_axi_bresp <= 2'h2;
        end
      end
    end
  end

  // Register read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (ce) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr[3:2])
          stve_pkg::ADDR_CTRL[3:2]: s_axi_rdata <= {24'h00_0000, ctrl_q[7:0]};
          stve_pkg::ADDR_STATUS[3:2]: s_axi_rdata <= {12'h000, fault, fault_vector, flags, 2'h0, cls_q};
          stve_pkg::ADDR_COUNT[3:2]: s_axi_rdata <= count_q;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_test_no_write: assert property (done && cls_q == stve_pkg::CLS_TEST |-> !result_we)
    else $error("logical compare wrote a result");
  a_test_clears_oc: assert property (done && cls_q == stve_pkg::CLS_TEST && !fault |->
    !flags[stve_pkg::FLAG_OVER] && !flags[stve_pkg::FLAG_CARRY] && flags_mask[stve_pkg::FLAG_CARRY])
    else $error("logical compare left overflow or carry set");
  a_undef_faults: assert property (fire && op_ext && op_byte == stve_pkg::OPC_EXT_UNDEF |=>
    done && fault && fault_vector == stve_pkg::VEC_INVALID_OPCODE)
    else $error("reserved opcode did not fault");
  a_undef_quiet: assert property (done && cls_q == stve_pkg::CLS_UNDEF |-> flags_mask == 6'h00 && !result_we)
    else $error("reserved opcode changed state");
  a_sub_result: assert property (fire && cls_d == stve_pkg::CLS_SUB && !fault_d |=>
    result_we && result == $past(sub_res))
    else $error("subtraction result wrong");
  a_sub_zero_flag: assert property (done && cls_q == stve_pkg::CLS_SUB && !fault |->
    flags[stve_pkg::FLAG_ZERO] == (result == 32'h0000_0000))
    else $error("zero flag disagrees with result");
  a_verify_no_fault: assert property (fire && (cls_d == stve_pkg::CLS_VRD || cls_d == stve_pkg::CLS_VWR) &&
    mode == stve_pkg::MODE_PROT && !mem_operand |=> !fault && flags_mask == stve_pkg::MASK_ZERO)
    else $error("verification raised a fault");
  a_verify_write_code: assert property (fire && cls_d == stve_pkg::CLS_VWR && desc_type[3] |=>
    !flags[stve_pkg::FLAG_ZERO])
    else $error("code segment verified writable");
  a_fault_no_write: assert property (fault && done |-> !result_we && flags_mask == 6'h00)
    else $error("faulting instruction wrote state");
  a_stack_limit: assert property (fire && mem_operand && seg_is_stack && cls_d == stve_pkg::CLS_SUB &&
    !(mode == stve_pkg::MODE_PROT && seg_is_data_reg && seg_null) && mem_end > {1'b0, seg_limit} |=>
    fault && fault_vector == stve_pkg::VEC_STACK)
    else $error("stack limit overrun not reported");

  c_sub_done: cover property (done && cls_q == stve_pkg::CLS_SUB && result_we);
  c_verify_pass: cover property (done && cls_q == stve_pkg::CLS_VRD && flags[stve_pkg::FLAG_ZERO]);
  c_page_fault: cover property (done && fault && fault_vector == stve_pkg::VEC_PAGE);
endmodule

// *** stve_pkg.sv ***
// Constants, types and register map of the subtract/test/verify execution unit
package stve_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ALIGN_BIT = 2;
  localparam int CTRL_PRIV_LSB = 3;
  localparam logic [1:0] MODE_REAL = 2'h0;
  localparam logic [1:0] MODE_PROT = 2'h1;
  localparam logic [1:0] MODE_V86 = 2'h2;
  localparam logic [1:0] PRIV_USER = 2'h3;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;
  localparam logic [7:0] OPC_SUB_RM8_R8 = 8'h28;
  localparam logic [7:0] OPC_SUB_RM_R = 8'h29;
  localparam logic [7:0] OPC_SUB_R8_RM8 = 8'h2A;
  localparam logic [7:0] OPC_SUB_R_RM = 8'h2B;
  localparam logic [7:0] OPC_SUB_AL_IMM = 8'h2C;
  localparam logic [7:0] OPC_SUB_ACC_IMM = 8'h2D;
  localparam logic [7:0] OPC_GRP1_RM8_IMM = 8'h80;
  localparam logic [7:0] OPC_GRP1_RM_IMM = 8'h81;
  localparam logic [7:0] OPC_GRP1_RM_IMM8 = 8'h83;
  localparam logic [7:0] OPC_TEST_RM8_R8 = 8'h84;
  localparam logic [7:0] OPC_TEST_RM_R = 8'h85;
  localparam logic [7:0] OPC_TEST_AL_IMM = 8'hA8;
  localparam logic [7:0] OPC_TEST_ACC_IMM = 8'hA9;
  localparam logic [7:0] OPC_GRP3_RM8 = 8'hF6;
  localparam logic [7:0] OPC_GRP3_RM = 8'hF7;
  localparam logic [7:0] OPC_EXT_UNDEF = 8'h0B;
  localparam logic [7:0] OPC_EXT_GRP6 = 8'h00;
  localparam logic [2:0] EXT_SUB = 3'h5;
  localparam logic [2:0] EXT_TEST = 3'h0;
  localparam logic [2:0] EXT_VERIFY_RD = 3'h4;
  localparam logic [2:0] EXT_VERIFY_WR = 3'h5;
  localparam logic [7:0] VEC_INVALID_OPCODE = 8'h06;
  localparam logic [7:0] VEC_STACK = 8'h0C;
  localparam logic [7:0] VEC_GENERAL = 8'h0D;
  localparam logic [7:0] VEC_PAGE = 8'h0E;
  localparam logic [7:0] VEC_ALIGN = 8'h11;
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_PARITY = 1;
  localparam int FLAG_AUX = 2;
  localparam int FLAG_ZERO = 3;
  localparam int FLAG_SIGN = 4;
  localparam int FLAG_OVER = 5;
  localparam logic [5:0] MASK_ALL = 6'h3F;
  localparam logic [5:0] MASK_TEST = 6'h3B;
  localparam logic [5:0] MASK_ZERO = 6'h08;
  typedef enum logic [2:0] {CLS_NONE, CLS_SUB, CLS_TEST, CLS_UNDEF, CLS_VRD, CLS_VWR} stve_cls_t;
endpackage

// *** sub_test_verify_exec_unit_tb.sv ***
// Self-checking bench for the subtract/test/verify execution unit
`timescale 1ns/100ps
module sub_test_verify_exec_unit_tb;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, issue_valid = 1'b0, op_ext = 1'b0;
  logic mem_operand = 1'b0, seg_is_stack = 1'b0, seg_is_data_reg = 1'b0, seg_null = 1'b0;
  logic seg_writable = 1'b1, page_fail = 1'b0, desc_in_table = 1'b1, desc_code_data = 1'b1;
  logic [7:0] op_byte = 8'h00;
  logic [2:0] modrm_reg = 3'h0;
  logic [1:0] op_size = 2'h0, desc_priv = 2'h0;
  logic [3:0] desc_type = 4'h0, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] dst_value = 32'h0, src_value = 32'h0, imm_value = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] mem_ea = 32'h0, seg_limit = 32'h0000_FFFF, page_fault_code = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic done, result_we, result_to_mem, fault, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [2:0] done_class;
  logic [5:0] flags_mask, flags;
  logic [7:0] fault_vector, taken, last_vec;
  logic [31:0] result, fault_code, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] sub_ops [9] = '{8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h80, 8'h81, 8'h83};
  logic [7:0] tst_ops [6] = '{8'hA8, 8'hA9, 8'hF6, 8'hF7, 8'h84, 8'h85};
  int bad_count = 0, total_checks = 0, nflt = 0;
  stve_exec_unit dut (.*);
  stve_exc_model exc (.aclk(aclk), .aresetn(aresetn), .done(done), .fault(fault),
    .fault_vector(fault_vector), .taken_q(taken), .last_vec_q(last_vec));
  initial forever #2 aclk = ~aclk;
  task automatic cm(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    tally_and_finish;
  endtask
  task automatic ex(input logic x, input logic [7:0] b, input logic [2:0] r, input logic [1:0] z,
    input logic [31:0] d, input logic [31:0] s, input logic [31:0] i);
    @(posedge aclk);
    issue_valid <= 1'b1;
    op_ext <= x;
    op_byte <= b;
    modrm_reg <= r;
    op_size <= z;
    dst_value <= d;
    src_value <= s;
    imm_value <= i;
    @(posedge aclk);
    issue_valid <= 1'b0;
    for (int n = 0; n < 4 && done !== 1'b1; n++) @(posedge aclk);
    if (done !== 1'b1) hang;
  endtask
  task automatic ck(input logic we, input logic [31:0] res, input logic [5:0] m, input logic [5:0] f,
    input logic fl, input logic [7:0] v, input logic [31:0] c);
    cm(result_we, we);
    if (we) cm(result, res);
    if (we) cm(result_to_mem, mem_operand && !(op_byte inside {8'h2A, 8'h2B}));
    cm(flags_mask, m);
    cm(flags & m, f);
    cm(fault, fl);
    if (fl) cm(fault_vector, v);
    if (fl) cm(fault_code, c);
    if (fl) nflt++;
  endtask
  task automatic vf(input logic [2:0] r, input logic [15:0] sel, input logic cd, input logic [3:0] t,
    input logic [1:0] p, input logic ok);
    desc_code_data <= cd;
    desc_type <= t;
    desc_priv <= p;
    ex(1'b1, 8'h00, r, 2'h1, 32'h0, {16'h0, sel}, 32'h0);
    ck(1'b0, 32'h0, 6'h08, {2'b00, ok, 3'b000}, 1'b0, 8'h00, 32'h0);
    cm(done_class, (r == 3'h4) ? stve_pkg::CLS_VRD : stve_pkg::CLS_VWR);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 8; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 8) hang;
    cm(s_axi_bresp, e);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 8; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 8) hang;
    cm(s_axi_rdata, d);
    cm(s_axi_rresp, e);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(4'h0, 32'h0, 2'h0);
    wr(4'hC, 32'h0, 2'h2);
    rd(4'hC, 32'h0, 2'h2);
    // Byte forms mask to eight bits, the rest run full width
    foreach (sub_ops[k]) begin
      ex(1'b0, sub_ops[k], 3'h5, 2'h2, 32'h5, 32'h7, 32'h7);
      ck(1'b1, sub_ops[k][0] ? 32'hFFFF_FFFE : 32'h0000_00FE, 6'h3F, 6'h15, 1'b0, 8'h00, 32'h0);
      cm(done_class, stve_pkg::CLS_SUB);
    end
    ex(1'b0, 8'h83, 3'h5, 2'h2, 32'h0, 32'h0, 32'h0000_00FF);
    ck(1'b1, 32'h1, 6'h3F, 6'h05, 1'b0, 8'h00, 32'h0);
    ex(1'b0, 8'h2D, 3'h0, 2'h1, 32'h8000, 32'h0, 32'h1);
    ck(1'b1, 32'h7FFF, 6'h3F, 6'h26, 1'b0, 8'h00, 32'h0);
    ex(1'b0, 8'h28, 3'h0, 2'h2, 32'h5, 32'h5, 32'h0);
    ck(1'b1, 32'h0, 6'h3F, 6'h0A, 1'b0, 8'h00, 32'h0);
    foreach (tst_ops[k]) begin
      ex(1'b0, tst_ops[k], 3'h0, 2'h2, 32'hF0, 32'h80, 32'h80);
      ck(1'b0, 32'h0, 6'h3B, tst_ops[k][0] ? 6'h00 : 6'h10, 1'b0, 8'h00, 32'h0);
      cm(done_class, stve_pkg::CLS_TEST);
    end
    for (int m = 0; m < 3; m++) begin
      wr(4'h0, m, 2'h0);
      ex(1'b1, 8'h0B, 3'h0, 2'h2, 32'h1, 32'h1, 32'h0);
      ck(1'b0, 32'h0, 6'h00, 6'h00, 1'b1, 8'h06, 32'h0);
      cm(done_class, stve_pkg::CLS_UNDEF);
    end
    ex(1'b1, 8'h00, 3'h4, 2'h1, 32'h0, 32'h8, 32'h0);
    ck(1'b0, 32'h0, 6'h00, 6'h00, 1'b1, 8'h06, 32'h0);
    wr(4'h0, 32'h1, 2'h0);
    vf(3'h4, 16'h0008, 1'b1, 4'hA, 2'h0, 1'b1);
    vf(3'h5, 16'h0008, 1'b1, 4'hA, 2'h0, 1'b0);
    vf(3'h5, 16'h0010, 1'b1, 4'h2, 2'h0, 1'b1);
    vf(3'h4, 16'h000B, 1'b1, 4'h2, 2'h0, 1'b0);
    vf(3'h4, 16'h000B, 1'b1, 4'hE, 2'h0, 1'b1);
    vf(3'h4, 16'h0008, 1'b0, 4'h2, 2'h0, 1'b0);
    vf(3'h4, 16'h0000, 1'b1, 4'h2, 2'h0, 1'b0);
    desc_in_table <= 1'b0;
    vf(3'h4, 16'h0008, 1'b1, 4'h2, 2'h0, 1'b0);
    desc_in_table <= 1'b1;
    wr(4'h0, 32'h19, 2'h0);
    vf(3'h5, 16'h000B, 1'b1, 4'h2, 2'h3, 1'b1);
    vf(3'h5, 16'h0008, 1'b1, 4'h2, 2'h2, 1'b0);
    wr(4'h0, 32'h1, 2'h0);
    mem_operand <= 1'b1;
    seg_writable <= 1'b0;
    ex(1'b0, 8'h29, 3'h0, 2'h2, 32'h5, 32'h7, 32'h0);
    ck(1'b0, 32'h0, 6'h00, 6'h00, 1'b1, 8'h0D, 32'h0);
    // Memory source with register destination may sit in a read-only segment
    ex(1'b0, 8'h2B, 3'h0, 2'h2, 32'h5, 32'h7, 32'h0);
    ck(1'b1, 32'hFFFF_FFFE, 6'h3F, 6'h15, 1'b0, 8'h00, 32'h0);
    seg_writable <= 1'b1;
    seg_is_data_reg <= 1'b1;
    seg_null <= 1'b1;
    ex(1'b0, 8'h85, 3'h0, 2'h2, 32'h5, 32'h7, 32'h0);
    ck(1'b0, 32'h0, 6'h00, 6'h00, 1'b1, 8'h0D, 32'h0);
    seg_null <= 1'b0;
    page_fail <= 1'b1;
    page_fault_code <= 32'h0000_0006;
    ex(1'b0, 8'h29, 3'h0, 2'h2, 32'h5, 32'h7, 32'h0);
    ck(1'b0, 32'h0, 6'h00, 6'h00, 1'b1, 8'h0E, 32'h6);
    page_fail <= 1'b0;
    mem_ea <= 32'h1;
    wr(4'h0, 32'h1D, 2'h0);
    rd(4'h0, 32'h1D, 2'h0);
    ex(1'b0, 8'h29, 3'h0, 2'h2, 32'h5, 32'h7, 32'h0);
    ck(1'b0, 32'h0, 6'h00, 6'h00, 1'b1, 8'h11, 32'h0);
    wr(4'h0, 32'h05, 2'h0);
    ex(1'b0, 8'h29, 3'h0, 2'h2, 32'h5, 32'h7, 32'h0);
    ck(1'b1, 32'hFFFF_FFFE, 6'h3F, 6'h15, 1'b0, 8'h00, 32'h0);
    wr(4'h0, 32'h0, 2'h0);
    seg_is_stack <= 1'b1;
    mem_ea <= 32'h0001_0000;
    ex(1'b0, 8'h29, 3'h0, 2'h2, 32'h5, 32'h7, 32'h0);
    ck(1'b0, 32'h0, 6'h00, 6'h00, 1'b1, 8'h0C, 32'h0);
    @(posedge aclk);
    cm(taken, nflt[7:0]);
    cm(last_vec, stve_pkg::VEC_STACK);
    // Enable low: a standing issue must not complete
    ce <= 1'b0;
    issue_valid <= 1'b1;
    repeat (3) @(posedge aclk);
    cm(done, 1'b0);
    ce <= 1'b1;
    issue_valid <= 1'b0;
    rd(4'h4, 32'h0008_6001, 2'h0);
    rd(4'h8, 32'h0000_001E, 2'h0);
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    hang;
  end
endmodule
